// ---- setpoint_conditioner.sv ----
// conditioning chain for the first analogue input: offset, window, filter, scaling
//
// Function
// - add signed offset, clamped to +-5000 mV
// - zero input within programmed dead window
// - first-order low-pass, updated every 250 us
// - time constant 0..32767 in 0.01 ms
// - current setpoint: scale at 10 V input
// - speed setpoint: scale at 10 V input
// - negative scale inverts setpoint polarity
// - clamp speed setpoint to maximum speed
`timescale 1ns/1ps
`include "setpoint_regs.svh"

module setpoint_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d;
  logic [AW-1:0] rd_q, rd_d;
  // one bit wider than the pointers so full and empty differ
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // both pointers wrap the same way, depth need not be a power of two
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : next_ptr

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = next_ptr(wr_q);
    end
    if (pop) begin
      rd_d = next_ptr(rd_q);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage needs no reset; reads are gated by the count
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule : setpoint_fifo

module setpoint_conditioner (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic signed [15:0] sample_mv_i,
  input wire logic speed_mode_i,
  input wire logic param_wr_i,
  input wire logic [15:0] param_addr_i,
  input wire logic [15:0] param_wdata_i,
  output logic [15:0] param_rdata_o,
  output logic param_err_o,
  output logic signed [15:0] filtered_mv_o,
  output logic setpoint_valid_o,
  input wire logic setpoint_ready_i,
  output logic setpoint_speed_o,
  output logic signed [15:0] setpoint_o,
  output logic overrun_o
);
  setpoint_pkg::cfg_type cfg_q, cfg_d;
  logic [15:0] tick_cnt_q, tick_cnt_d;
  logic tick;
  logic push_q, push_d;
  logic signed [31:0] y_q, y_d;
  logic signed [15:0] filt_q, filt_d;
  logic overrun_q, overrun_d;
  logic fifo_ready;
  logic [16:0] fifo_out;
  setpoint_pkg::setpoint_type sp;

  // symmetric signed limit, used for the offset, both scales and the setpoint
  function automatic logic signed [31:0] sat(input logic signed [31:0] v, input logic signed [31:0] lim);
    if (v > lim) begin
      sat = lim;
    end else if (v < -lim) begin
      sat = -lim;
    end else begin
      sat = v;
    end
  endfunction : sat

  // out-of-range writes saturate instead of being refused
  function automatic logic [15:0] ucap(input logic [15:0] v, input logic [15:0] lim);
    ucap = (v > lim) ? lim : v;
  endfunction : ucap

  function automatic logic [15:0] scap(input logic [15:0] v, input logic signed [31:0] lim);
    scap = 16'(sat(32'(signed'(v)), lim));
  endfunction : scap

  // param writes; values outside the documented range saturate
  always_comb begin
    cfg_d = cfg_q;
    param_err_o = 1'b0;
    param_rdata_o = 16'h0000;
    case (param_addr_i)
      `TAU_OFFSET: param_rdata_o = cfg_q.tau;
      `WIN_OFFSET: param_rdata_o = cfg_q.win;
      `OFS_OFFSET: param_rdata_o = cfg_q.ofs;
      `ISCALE_OFFSET: param_rdata_o = cfg_q.iscale;
      `NSCALE_OFFSET: param_rdata_o = cfg_q.nscale;
      `NMAX_OFFSET: param_rdata_o = cfg_q.nmax;
      default: param_err_o = 1'b1;
    endcase
    if (param_wr_i) begin
      case (param_addr_i)
        `TAU_OFFSET: begin
          cfg_d.tau = ucap(param_wdata_i, 16'(`TAU_MAX));
        end
        `WIN_OFFSET: begin
          cfg_d.win = ucap(param_wdata_i, 16'(`WIN_MAX));
        end
        `OFS_OFFSET: begin
          cfg_d.ofs = scap(param_wdata_i, `OFS_MAX);
        end
        `ISCALE_OFFSET: begin
          cfg_d.iscale = scap(param_wdata_i, `SCALE_LIM);
        end
        `NSCALE_OFFSET: begin
          cfg_d.nscale = scap(param_wdata_i, `SCALE_LIM);
        end
        `NMAX_OFFSET: begin
          cfg_d.nmax = ucap(param_wdata_i, 16'(`SCALE_LIM));
        end
        default: begin
          cfg_d = cfg_q;
        end
      endcase
    end
  end

  always_comb begin
    tick = (tick_cnt_q == 16'(`SAMPLE_CYCLES - 1));
    tick_cnt_d = tick ? 16'h0000 : tick_cnt_q + 16'h0001;
    // setpoint pushed one cycle after the filter update
    push_d = tick;
  end

  // conditioning and filter, evaluated once per sample tick
  always_comb begin
    logic signed [31:0] x;
    logic signed [31:0] d;
    logic signed [31:0] tgt;
    logic signed [31:0] prod;
    logic signed [31:0] w;
    x = 32'sd0;
    d = 32'sd0;
    tgt = 32'sd0;
    prod = 32'sd0;
    w = 32'sd0;
    y_d = y_q;
    filt_d = filt_q;
    overrun_d = overrun_q;
    x = 32'(sample_mv_i) + 32'(cfg_q.ofs);
    // dead window at zero
    // compared signed, else negative inputs never fall inside
    w = 32'(cfg_q.win);
    if (x <= w && x >= -w) begin
      x = 32'sd0;
    end
    // filter state carries 8 fraction bits so slow filters still creep
    tgt = x <<< 8;
    if (tick) begin
      if (cfg_q.tau == 16'h0000) begin
        y_d = tgt;
      end else begin
        // pt1 step, tau in 10 us units
        d = tgt - y_q;
        prod = (d * `SAMPLE_TAU_UNITS) / $signed({16'h0000, cfg_q.tau});
        // step never overshoots when tau is below the sample period
        y_d = (cfg_q.tau <= 16'(`SAMPLE_TAU_UNITS)) ? tgt : y_q + prod;
      end
      filt_d = 16'(y_d >>> 8);
      // judged at the tick; the push itself follows a cycle later
      overrun_d = overrun_q | ~fifo_ready;
    end
  end

  always_comb begin
    logic signed [47:0] p;
    logic signed [31:0] s;
    p = 48'sd0;
    s = 32'sd0;
    sp.speed = speed_mode_i;
    if (speed_mode_i) begin
      p = 48'(filt_q) * 48'(cfg_q.nscale);
    end else begin
      p = 48'(filt_q) * 48'(cfg_q.iscale);
    end
    s = 32'(p / 48'(`FULL_SCALE_MV));
    if (speed_mode_i) begin
      s = sat(s, 32'({16'h0000, cfg_q.nmax}));
    end else begin
      s = sat(s, `SCALE_LIM);
    end
    sp.value = 16'(s);
  end

  // parameters survive only until reset; no persistent store here
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_q.tau <= `TAU_RESET;
      cfg_q.win <= `WIN_RESET;
      cfg_q.ofs <= `OFS_RESET;
      cfg_q.iscale <= `ISCALE_RESET;
      cfg_q.nscale <= `NSCALE_RESET;
      cfg_q.nmax <= `NMAX_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt_q <= 16'h0000;
      push_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      push_q <= push_d;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      y_q <= 32'sd0;
      filt_q <= 16'sd0;
      overrun_q <= 1'b0;
    end else begin
      y_q <= y_d;
      filt_q <= filt_d;
      overrun_q <= overrun_d;
    end
  end

  // sample dropped when control loop lags four periods; overrun stays set
  setpoint_fifo #(.WIDTH(17), .DEPTH(4)) u_fifo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(push_q),
    .in_ready_o(fifo_ready),
    .in_data_i(sp),
    .out_valid_o(setpoint_valid_o),
    .out_ready_i(setpoint_ready_i),
    .out_data_o(fifo_out)
  );

  assign setpoint_speed_o = fifo_out[16];
  assign setpoint_o = fifo_out[15:0];
  assign filtered_mv_o = filt_q;
  assign overrun_o = overrun_q;
endmodule : setpoint_conditioner

// ---- setpoint_conditioner_chk.sv ----
// port assertions for the setpoint conditioner
`timescale 1ns/1ps
module setpoint_conditioner_chk (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic param_wr_i,
  input wire logic [15:0] param_addr_i,
  input wire logic [15:0] param_wdata_i,
  input wire logic [15:0] param_rdata_o,
  input wire logic signed [15:0] filtered_mv_o,
  input wire logic setpoint_valid_o,
  input wire logic setpoint_ready_i,
  input wire logic signed [15:0] setpoint_o,
  input wire logic overrun_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // readback only judged while the address is held
  ofs_store_a: assert property (param_wr_i && param_addr_i == 16'h0916 && $signed(param_wdata_i) <= 5000
    && $signed(param_wdata_i) >= -5000 |=> param_rdata_o == $past(param_wdata_i) || $changed(param_addr_i))
    else $error("offset");
  win_limit_a: assert property (param_wr_i && param_addr_i == 16'h0912 && param_wdata_i > 16'h03e8
    |=> param_rdata_o == 16'h03e8 || $changed(param_addr_i)) else $error("window");
  tau_limit_a: assert property (param_wr_i && param_addr_i == 16'h0904 && param_wdata_i[15]
    |=> param_rdata_o == 16'h7fff || $changed(param_addr_i)) else $error("tau");
  iscale_limit_a: assert property (param_wr_i && param_addr_i == 16'h2006 && $signed(param_wdata_i) > 30000
    |=> param_rdata_o == 16'h7530 || $changed(param_addr_i)) else $error("scale");
  filt_tick_a: assert property (!$stable(filtered_mv_o) |=> $stable(filtered_mv_o) [*8]) else $error("rate");
  sp_range_a: assert property (setpoint_valid_o |-> setpoint_o >= -30000 && setpoint_o <= 30000)
    else $error("range");
  sp_hold_a: assert property (setpoint_valid_o && !setpoint_ready_i |=> setpoint_valid_o && $stable(setpoint_o))
    else $error("hold");
  overrun_keep_a: assert property (overrun_o |=> overrun_o) else $error("overrun");
endmodule : setpoint_conditioner_chk
bind setpoint_conditioner setpoint_conditioner_chk chk (.*);

// ---- setpoint_pkg.sv ----
// types shared by the setpoint conditioner
package setpoint_pkg;
  typedef enum logic {current_mode_type_e, speed_mode_type_e} ctrl_mode_type;
  typedef struct packed {
    logic [15:0] tau;
    logic [15:0] win;
    logic signed [15:0] ofs;
    logic signed [15:0] iscale;
    logic signed [15:0] nscale;
    logic [15:0] nmax;
  } cfg_type;
  typedef struct packed {
    logic speed;
    logic signed [15:0] value;
  } setpoint_type;
endpackage : setpoint_pkg

// ---- setpoint_regs.svh ----
// register offsets, reset values and timing counts of the setpoint conditioner
`ifndef SETPOINT_REGS_SVH
`define SETPOINT_REGS_SVH
`define TAU_OFFSET 16'h0904
`define WIN_OFFSET 16'h0912
`define OFS_OFFSET 16'h0916
`define ISCALE_OFFSET 16'h2006
`define NSCALE_OFFSET 16'h2106
`define NMAX_OFFSET 16'h2200
`define TAU_RESET 16'h0000
`define WIN_RESET 16'h0000
`define OFS_RESET 16'h0000
`define ISCALE_RESET 16'h012c
`define NSCALE_RESET 16'h0bb8
`define NMAX_RESET 16'h7530
`define OFS_MIN (-5000)
`define OFS_MAX 5000
`define WIN_MAX 1000
`define TAU_MAX 32767
`define SCALE_LIM 30000
`define FULL_SCALE_MV 10000
`define CLK_HZ 50000000
`define SAMPLE_US 250
`define SAMPLE_CYCLES ((`CLK_HZ / 1000000) * `SAMPLE_US)
// tau unit is 10 us, so period in tau units is 25
`define SAMPLE_TAU_UNITS (`SAMPLE_US / 10)
`endif

// ---- setpoint_source.sv ----
// analogue source model: converter output for the first input
`timescale 1ns/1ps
module setpoint_source (
  input wire logic clk_i,
  input wire logic signed [15:0] level_i,
  output logic signed [15:0] mv_o
);
  // one-cycle converter delay, far inside a sample period
  always_ff @(posedge clk_i) mv_o <= level_i;
endmodule : setpoint_source

// ---- tb.sv ----
// bench for the setpoint conditioner
`timescale 1ns/1ps
module tb;
  logic clk_i = 0, arst_n_i = 0, spd = 0, wr = 0, rdy = 0, vld, kind, err, ovr;
  logic [15:0] addr = '0, wd = '0, rd;
  logic signed [15:0] lvl = '0, mv, filt, sp;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  logic [16:0] q[$];
  setpoint_source src (.clk_i, .level_i(lvl), .mv_o(mv));
  setpoint_conditioner dut (.clk_i, .arst_n_i, .sample_mv_i(mv), .speed_mode_i(spd), .param_wr_i(wr),
    .param_addr_i(addr), .param_wdata_i(wd), .param_rdata_o(rd), .param_err_o(err), .filtered_mv_o(filt),
    .setpoint_valid_o(vld), .setpoint_ready_i(rdy), .setpoint_speed_o(kind), .setpoint_o(sp), .overrun_o(ovr));
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (arst_n_i) cyc <= cyc + 1;
  task chk(input logic [17:0] s, input logic [17:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task final_report;
    $display("%0d checks, %0d mismatches", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task put(input logic [15:0] a, input logic [15:0] d);
    wr <= 1;
    addr <= a;
    wd <= d;
    @(posedge clk_i);
    wr <= 0;
    @(posedge clk_i);
  endtask : put
  task rr(input logic [15:0] a, input logic [16:0] e);
    addr <= a;
    @(posedge clk_i);
    #1;
    chk({err, rd}, e);
  endtask : rr
  // ticks fall every 12500 cycles, so waits are by cycle count
  task upto(input int n, input logic [15:0] f);
    for (int i = 0; i < 70000 && cyc < n; i++) @(posedge clk_i);
    #1;
    if (cyc < n) begin
      n_mismatch++;
      final_report;
    end
    chk(filt, f);
  endtask : upto
  initial begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1;
    @(posedge clk_i);
    rr(16'h0904, 17'h0);
    rr(16'h0912, 17'h0);
    rr(16'h0916, 17'h0);
    rr(16'h2006, 17'h012c);
    rr(16'h2106, 17'h0bb8);
    rr(16'h0aaa, 17'h10000);
    put(16'h0916, 16'h1389);
    rr(16'h0916, 17'h1388);
    put(16'h0912, 16'hffff);
    rr(16'h0912, 17'h03e8);
    put(16'h0904, 16'hffff);
    put(16'h2006, 16'h7fff);
    put(16'h0916, 16'h0064);
    put(16'h0912, 16'h0014);
    put(16'h0904, 16'h0000);
    spd <= 1;
    lvl <= 16'hff92;
    q = '{17'h10000, 17'h105fa, 17'h1fc18, 17'h0007b};
    upto(12510, 16'h0000);
    lvl <= 16'h1388;
    upto(25010, 16'h13ec);
    put(16'h2106, 16'h8ad0);
    put(16'h2200, 16'h03e8);
    upto(37510, 16'h13ec);
    put(16'h0904, 16'h0064);
    put(16'h2006, 16'h012c);
    spd <= 0;
    lvl <= 16'h03e8;
    upto(50010, 16'h1004);
    chk(ovr, 1'b0);
    upto(62510, 16'h0d16);
    chk(ovr, 1'b1);
    repeat (4) begin
      chk({vld, kind, sp}, {1'b1, q.pop_front()});
      rdy <= 1;
      @(posedge clk_i);
      rdy <= 0;
      @(posedge clk_i);
      #1;
    end
    chk(vld, 1'b0);
    final_report;
  end
endmodule : tb
